/* fifo_flag_map.svh */
`ifndef FIFO_FLAG_MAP_SVH
`define FIFO_FLAG_MAP_SVH

// storage depth and offset defaults
`define FFO_DEPTH        1024
`define FFO_OFS_DEFAULT  9'h007

// register byte offsets on the avalon slave
`define FFO_REG_STATUS   4'h0
`define FFO_REG_MASK     4'h4
`define FFO_REG_LEVEL    4'h8
`define FFO_REG_OFFSETS  4'hc

// event bit positions, shared by status and mask
`define FFO_EV_EMPTY     0
`define FFO_EV_AEMPTY    1
`define FFO_EV_AFULL     2
`define FFO_EV_FULL      3
`define FFO_EV_OVERRUN   4
`define FFO_EV_W         5
`define FFO_MASK_RESET   5'h00

// level register field positions
`define FFO_LVL_FLAGS    16
`define FFO_LVL_MODE     20

`endif

/* fifo_flag_pkg.sv */
package fifo_flag_pkg;

    // one nine-bit data word
    typedef logic [8:0] word_t;

    // offset register selection order, gray along the load path
    typedef enum logic [1:0] {
        SEL_EMPTY_LO = 2'b00,
        SEL_EMPTY_HI = 2'b01,
        SEL_FULL_LO  = 2'b11,
        SEL_FULL_HI  = 2'b10
    } sel_e;

endpackage

/* word_store.sv */
`timescale 1ns/10ps

module word_store #(
    parameter int DEPTH = 1024
) (
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    input  wire logic                 wr_i,
    input  wire fifo_flag_pkg::word_t wdata_i,
    input  wire logic                 rd_i,
    output fifo_flag_pkg::word_t      head_o
);
    import fifo_flag_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    word_t            mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;

    ////////////////////////////////////////////////////////////////////////
    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else
        begin
            if (wr_i)
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            if (rd_i)
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
        end
    end

    // data array needs no reset, the count guards every read
    always_ff @(posedge clk_i)
    begin
        if (wr_i)
            mem[wr_ptr_q] <= wdata_i;
    end

    assign head_o = mem[rd_ptr_q];

endmodule

/* flag_offset_regs.sv */
`timescale 1ns/10ps
`include "fifo_flag_map.svh"

module flag_offset_regs #(
    parameter int OFS_W = 10
) (
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    input  wire logic                 load_wr_i,
    input  wire logic                 load_rd_i,
    input  wire fifo_flag_pkg::word_t data_i,
    output logic [OFS_W-1:0]          empty_ofs_o,
    output logic [OFS_W-1:0]          full_ofs_o,
    output fifo_flag_pkg::word_t      sel_word_o
);
    import fifo_flag_pkg::*;

    sel_e       sel_q;
    word_t      part_q [4];
    logic [1:0] slot;

    // gray selection code to physical slot index
    assign slot = {sel_q[1], sel_q[1] ^ sel_q[0]};

    ////////////////////////////////////////////////////////////////////////
    // loads and reads walk the same order, so one pointer serves both
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            sel_q <= SEL_EMPTY_LO;
        else if (load_wr_i || load_rd_i)
        begin
            case (sel_q)
                SEL_EMPTY_LO: sel_q <= SEL_EMPTY_HI;
                SEL_EMPTY_HI: sel_q <= SEL_FULL_LO;
                SEL_FULL_LO:  sel_q <= SEL_FULL_HI;
                SEL_FULL_HI:  sel_q <= SEL_EMPTY_LO;
                default:      sel_q <= SEL_EMPTY_LO;
            endcase
        end
    end

    // one slot per nine-bit part; low parts reset to the default offset
    for (genvar i = 0; i < 4; i++)
    begin : g_part
        always_ff @(posedge clk_i)
        begin
            if (srst_i)
                part_q[i] <= (i % 2 == 0) ? `FFO_OFS_DEFAULT : 9'h000;
            else if (load_wr_i && slot == 2'(i))
                part_q[i] <= data_i;
        end
    end

    // upper bits beyond the offset width are kept but not used
    assign empty_ofs_o = OFS_W'({part_q[1], part_q[0]});
    assign full_ofs_o  = OFS_W'({part_q[3], part_q[2]});
    assign sel_word_o  = part_q[slot];

endmodule

/* fifo_flag_offset_logic.sv */
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "fifo_flag_map.svh"
// What this block does
// - almost-full low at depth minus m words
// - almost-full changes on the write edge itself
// - offsets read back in load order
// - empty offset n defaults to seven
// - full offset m defaults to seven
// - first word readable cycle after empty clears
// - first-read latency only from empty state
// - strap at reset picks enable or load
// - read at almost-empty edge leaves n-1
module fifo_flag_offset_logic #(
    parameter int DEPTH = `FFO_DEPTH
) (
    input  wire logic                 REF_CLK_I,
    input  wire logic                 SRST_I,
    input  wire fifo_flag_pkg::word_t WR_DATA_I,
    input  wire logic                 WRITE_ENABLE_A_N_I,
    input  wire logic                 SECOND_WRITE_ENABLE_OR_LOAD_I,
    input  wire logic                 READ_ENABLE_A_N_I,
    input  wire logic                 READ_ENABLE_B_N_I,
    output fifo_flag_pkg::word_t      RD_DATA_O,
    output logic                      EMPTY_FLAG_N_O,
    output logic                      FULL_FLAG_N_O,
    output logic                      ALMOST_EMPTY_FLAG_N_O,
    output logic                      ALMOST_FULL_FLAG_N_O,
    input  wire logic [3:0]           AVS_ADDRESS_I,
    input  wire logic                 AVS_READ_I,
    input  wire logic                 AVS_WRITE_I,
    input  wire logic [31:0]          AVS_WRITEDATA_I,
    input  wire logic [3:0]           AVS_BYTEENABLE_I,
    output logic [31:0]               AVS_READDATA_O,
    output logic                      AVS_WAITREQUEST_O,
    output logic                      IRQ_O
);
    import fifo_flag_pkg::*;

    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int OFS_W = $clog2(DEPTH);

    logic                 load_mode_q;
    logic [CNT_W-1:0]     count_q;
    logic [CNT_W-1:0]     count_d;
    logic [CNT_W-1:0]     full_thr;
    logic [OFS_W-1:0]     empty_ofs;
    logic [OFS_W-1:0]     full_ofs;
    word_t                head_w;
    word_t                sel_word;
    logic                 ld_sel;
    logic                 load_wr;
    logic                 load_rd;
    logic                 rd_both;
    logic                 wr_req;
    logic                 rd_req;
    logic                 wr_fire;
    logic                 rd_fire;
    logic                 e_n_d;
    logic                 f_n_d;
    logic                 ae_n_d;
    logic                 af_n_d;
    logic [`FFO_EV_W-1:0] ev;
    logic [`FFO_EV_W-1:0] status_q;
    logic [`FFO_EV_W-1:0] status_d;
    logic [`FFO_EV_W-1:0] mask_q;
    logic [`FFO_EV_W-1:0] mask_d;
    logic [31:0]          be_mask;
    logic                 bus_wr;
    logic                 bus_rd;

    ////////////////////////////////////////////////////////////////////////
    // strap caught while reset is held, fixed until the next reset
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
            load_mode_q <= !SECOND_WRITE_ENABLE_OR_LOAD_I;
    end

    // pin decode; in load mode the low pin steers to the offset registers
    assign ld_sel  = load_mode_q && !SECOND_WRITE_ENABLE_OR_LOAD_I;
    assign load_wr = ld_sel && !WRITE_ENABLE_A_N_I;
    assign rd_both = !READ_ENABLE_A_N_I && !READ_ENABLE_B_N_I;
    assign load_rd = ld_sel && rd_both;
    assign wr_req  = !WRITE_ENABLE_A_N_I && SECOND_WRITE_ENABLE_OR_LOAD_I;
    assign rd_req  = rd_both && !ld_sel;
    // full and empty refuse silently; overrun is reported as an event
    assign wr_fire = wr_req && FULL_FLAG_N_O;
    assign rd_fire = rd_req && EMPTY_FLAG_N_O;

    ////////////////////////////////////////////////////////////////////////
    flag_offset_regs #(
        .OFS_W       (OFS_W)
    ) u_offsets (
        .clk_i       (REF_CLK_I),
        .srst_i      (SRST_I),
        .load_wr_i   (load_wr),
        .load_rd_i   (load_rd),
        .data_i      (WR_DATA_I),
        .empty_ofs_o (empty_ofs),
        .full_ofs_o  (full_ofs),
        .sel_word_o  (sel_word)
    );

    word_store #(
        .DEPTH   (DEPTH)
    ) u_store (
        .clk_i   (REF_CLK_I),
        .srst_i  (SRST_I),
        .wr_i    (wr_fire),
        .wdata_i (WR_DATA_I),
        .rd_i    (rd_fire),
        .head_o  (head_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // word count and flag thresholds
    always_comb
    begin
        count_d = count_q;
        if (wr_fire && !rd_fire)
            count_d = count_q + 1'b1;
        else if (rd_fire && !wr_fire)
            count_d = count_q - 1'b1;
    end

    assign full_thr = CNT_W'(DEPTH) - CNT_W'(full_ofs);
    assign e_n_d    = (count_d != '0);
    assign f_n_d    = (count_d != CNT_W'(DEPTH));
    assign ae_n_d   = (count_d > CNT_W'(empty_ofs));
    assign af_n_d   = (count_d < full_thr);

    // one clock for both ports, so the skew minimum is always met and
    // flags never need the deferred update that two clocks would allow
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            count_q               <= '0;
            EMPTY_FLAG_N_O        <= 1'b0;
            FULL_FLAG_N_O         <= 1'b1;
            ALMOST_EMPTY_FLAG_N_O <= 1'b0;
            ALMOST_FULL_FLAG_N_O  <= 1'b1;
        end
        else
        begin
            count_q               <= count_d;
            EMPTY_FLAG_N_O        <= e_n_d;
            FULL_FLAG_N_O         <= f_n_d;
            ALMOST_EMPTY_FLAG_N_O <= ae_n_d;
            ALMOST_FULL_FLAG_N_O  <= af_n_d;
        end
    end

    // output word: fifo head on a read, selected offset in load mode
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
            RD_DATA_O <= '0;
        else if (load_rd)
            RD_DATA_O <= sel_word;
        else if (rd_fire)
            RD_DATA_O <= head_w;
    end

    ////////////////////////////////////////////////////////////////////////
    // events: a flag entering its active state, or a write when full
    assign ev[`FFO_EV_EMPTY]   = EMPTY_FLAG_N_O && !e_n_d;
    assign ev[`FFO_EV_AEMPTY]  = ALMOST_EMPTY_FLAG_N_O && !ae_n_d;
    assign ev[`FFO_EV_AFULL]   = ALMOST_FULL_FLAG_N_O && !af_n_d;
    assign ev[`FFO_EV_FULL]    = FULL_FLAG_N_O && !f_n_d;
    assign ev[`FFO_EV_OVERRUN] = wr_req && !FULL_FLAG_N_O;

    // one wait cycle per access; read data captured as the request arrives, write data once waitrequest drops
    assign bus_wr  = AVS_WRITE_I && !AVS_WAITREQUEST_O;
    assign bus_rd  = AVS_READ_I && AVS_WAITREQUEST_O;
    assign be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                      {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};

    // write one to clear; a new event in the same cycle wins
    always_comb
    begin
        status_d = status_q;
        mask_d   = mask_q;
        if (bus_wr && AVS_ADDRESS_I == `FFO_REG_STATUS)
            status_d = status_q & ~`FFO_EV_W'(AVS_WRITEDATA_I & be_mask);
        if (bus_wr && AVS_ADDRESS_I == `FFO_REG_MASK)
            mask_d = (mask_q & ~`FFO_EV_W'(be_mask))
                   | `FFO_EV_W'(AVS_WRITEDATA_I & be_mask);
        status_d = status_d | ev;
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            status_q <= '0;
            mask_q   <= `FFO_MASK_RESET;
            IRQ_O    <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            mask_q   <= mask_d;
            IRQ_O    <= |(status_d & mask_d);
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
            AVS_WAITREQUEST_O <= 1'b1;
        else
            AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
    end

    // unmapped addresses read as zero and ignore writes
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
            AVS_READDATA_O <= '0;
        else if (bus_rd)
        begin
            case (AVS_ADDRESS_I)
                `FFO_REG_STATUS:  AVS_READDATA_O <= 32'(status_q);
                `FFO_REG_MASK:    AVS_READDATA_O <= 32'(mask_q);
                `FFO_REG_LEVEL:   AVS_READDATA_O <= {11'h000, load_mode_q,
                                      FULL_FLAG_N_O, ALMOST_FULL_FLAG_N_O,
                                      ALMOST_EMPTY_FLAG_N_O, EMPTY_FLAG_N_O,
                                      16'(count_q)};
                `FFO_REG_OFFSETS: AVS_READDATA_O <= {16'(full_ofs), 16'(empty_ofs)};
                default:          AVS_READDATA_O <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);

    sequence s_fill;
        wr_fire && count_q == '0;
    endsequence

    sequence s_first_read;
        s_fill ##1 (EMPTY_FLAG_N_O && rd_fire);
    endsequence

    almost_full_level_a: assert property (
        $stable(full_ofs) && !$past(load_wr) |-> ((count_q >= full_thr) == !ALMOST_FULL_FLAG_N_O))
        else $error("almost-full flag disagrees with word count");

    almost_full_step_a: assert property (
        wr_fire && !rd_fire && !load_wr && count_q == full_thr - 1'b1
        |=> !ALMOST_FULL_FLAG_N_O)
        else $error("almost-full flag late by more than one edge");

    offset_readback_a: assert property (
        load_rd && !load_wr |=> RD_DATA_O == $past(sel_word))
        else $error("offset readback does not follow selection order");

    offset_default_a: assert property (
        $fell(SRST_I) |-> empty_ofs == OFS_W'(`FFO_OFS_DEFAULT)
                          && full_ofs == OFS_W'(`FFO_OFS_DEFAULT))
        else $error("offsets not at default after reset");

    first_word_a: assert property (
        s_first_read |=> RD_DATA_O == $past(WR_DATA_I, 2))
        else $error("first word not readable after empty clears");

    first_latency_a: assert property (
        s_fill |=> EMPTY_FLAG_N_O ##0 (count_q == CNT_W'(1) || !$past(rd_fire)))
        else $error("empty flag did not clear one edge after first write");

    strap_capture_a: assert property (
        $fell(SRST_I) |-> load_mode_q == !$past(SECOND_WRITE_ENABLE_OR_LOAD_I))
        else $error("strap not captured at reset release");

    almost_empty_read_a: assert property (
        rd_fire && !wr_fire && !load_wr && count_q == CNT_W'(empty_ofs)
        |=> !ALMOST_EMPTY_FLAG_N_O && count_q == CNT_W'(empty_ofs) - 1'b1)
        else $error("read at almost-empty edge left wrong count");

    almost_full_release_a: assert property (
        rd_fire && !wr_fire && !load_wr && count_q == full_thr
        |=> ALMOST_FULL_FLAG_N_O [*2] or (ALMOST_FULL_FLAG_N_O ##1 !ALMOST_FULL_FLAG_N_O))
        else $error("almost-full did not release below threshold");

    almost_empty_level_a: assert property (
        $stable(empty_ofs) && !$past(load_wr)
        |-> ((count_q <= CNT_W'(empty_ofs)) == !ALMOST_EMPTY_FLAG_N_O))
        else $error("almost-empty flag disagrees with word count");

    empty_level_a: assert property (
        (count_q == '0) == !EMPTY_FLAG_N_O)
        else $error("empty flag disagrees with word count");

    // a clear landing with a new overrun must not lose the event
    event_sticky_a: assert property (
        ev[`FFO_EV_OVERRUN] |=> status_q[`FFO_EV_OVERRUN])
        else $error("overrun event lost against a clear");

    bus_answer_a: assert property (
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("waitrequest did not drop one cycle after request");

    irq_level_a: assert property (
        (|(status_q & mask_q)) |-> IRQ_O)
        else $error("interrupt low while unmasked status set");

endmodule

/* stream_endpoint.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// far-side writer and reader; every request lasts exactly one clock edge
module stream_endpoint (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 strap_i,
    input  wire fifo_flag_pkg::word_t rd_data_i,
    output fifo_flag_pkg::word_t      wr_data_o,
    output logic                      wen_a_n_o,
    output logic                      pin_o,
    output logic                      ren_a_n_o,
    output logic                      ren_b_n_o
);
    import fifo_flag_pkg::*;

    logic pin_q;

    // idle levels at time zero
    initial
    begin
        wr_data_o = 9'h000;
        wen_a_n_o = 1'b1;
        ren_a_n_o = 1'b1;
        ren_b_n_o = 1'b1;
        pin_q     = 1'b1;
    end

    // strap shows only while reset is held, idle high afterwards
    assign pin_o = rst_i ? strap_i : pin_q;

    ////////////////////////////////////////////////////////////////////////////////
    // one write; released data shows the inverse so stale words cannot pass
    task automatic push(input word_t w);
        wr_data_o <= w;
        wen_a_n_o <= 1'b0;
        @(posedge clk_i);
        wen_a_n_o <= 1'b1;
        wr_data_o <= ~w;
    endtask

    // one read; word is taken at the edge after the read edge
    task automatic pop(output word_t w);
        ren_a_n_o <= 1'b0;
        ren_b_n_o <= 1'b0;
        @(posedge clk_i);
        ren_a_n_o <= 1'b1;
        ren_b_n_o <= 1'b1;
        @(posedge clk_i);
        w = rd_data_i;
    endtask

    // four offset parts on four back-to-back edges, in selection order
    task automatic load_parts(input word_t p [4]);
        for (int i = 0; i < 4; i++)
        begin
            wr_data_o <= p[i];
            wen_a_n_o <= 1'b0;
            pin_q     <= 1'b0;
            @(posedge clk_i);
        end
        wen_a_n_o <= 1'b1;
        pin_q     <= 1'b1;
        wr_data_o <= ~p[3];
    endtask

    // read back the same order, both read enables low with the load select
    task automatic load_readback(output word_t p [4]);
        ren_a_n_o <= 1'b0;
        ren_b_n_o <= 1'b0;
        pin_q     <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 4; i++)
        begin
            if (i == 3)
            begin
                ren_a_n_o <= 1'b1;
                ren_b_n_o <= 1'b1;
                pin_q     <= 1'b1;
            end
            @(posedge clk_i);
            p[i] = rd_data_i;
        end
    endtask
endmodule

/* fifo_flag_offset_logic_test.sv */
`timescale 1ns/10ps
`include "fifo_flag_map.svh"
module fifo_flag_offset_logic_test;
    import fifo_flag_pkg::*;

    localparam int DEPTH = 16; // shrunk so a fill stays short

    logic        clk;
    logic        srst;
    logic        strap;
    logic [3:0]  avs_addr;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_wdata;
    logic [31:0] rdata;
    logic        wait_req;
    logic        irq;
    word_t       wr_data;
    word_t       rd_data;
    logic        wen_a_n;
    logic        pin;
    logic        ren_a_n;
    logic        ren_b_n;
    logic        empty_n;
    logic        full_n;
    logic        aempty_n;
    logic        afull_n;
    logic [3:0]  avs_be;
    logic [31:0] d;
    word_t       w;
    word_t       parts [4];
    word_t       back [4];
    int          fail_count;
    int          samples_checked;

    fifo_flag_offset_logic #(.DEPTH(DEPTH)) dut (
        .REF_CLK_I(clk), .SRST_I(srst), .WR_DATA_I(wr_data),
        .WRITE_ENABLE_A_N_I(wen_a_n), .SECOND_WRITE_ENABLE_OR_LOAD_I(pin),
        .READ_ENABLE_A_N_I(ren_a_n), .READ_ENABLE_B_N_I(ren_b_n), .RD_DATA_O(rd_data),
        .EMPTY_FLAG_N_O(empty_n), .FULL_FLAG_N_O(full_n), .ALMOST_EMPTY_FLAG_N_O(aempty_n),
        .ALMOST_FULL_FLAG_N_O(afull_n), .AVS_ADDRESS_I(avs_addr), .AVS_READ_I(avs_read),
        .AVS_WRITE_I(avs_write), .AVS_WRITEDATA_I(avs_wdata), .AVS_BYTEENABLE_I(avs_be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req), .IRQ_O(irq));

    stream_endpoint far (
        .clk_i(clk), .rst_i(srst), .strap_i(strap), .rd_data_i(rd_data),
        .wr_data_o(wr_data), .wen_a_n_o(wen_a_n), .pin_o(pin),
        .ren_a_n_o(ren_a_n), .ren_b_n_o(ren_b_n));

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // comparisons, one per kind of result
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic chk_word(input word_t got, input word_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // avalon master; an idle edge follows each access so no signal is set twice
    task automatic avs_rd(input logic [3:0] a, output logic [31:0] q);
        int n;
        n = 0;
        avs_addr <= a;
        avs_read <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_req !== 1'b0 && n < 64);
        q = rdata;
        avs_read <= 1'b0;
        if (n >= 64)
            fail_count++;
        @(posedge clk);
    endtask

    task automatic avs_wr(input logic [3:0] a, input logic [31:0] v);
        int n;
        n = 0;
        avs_addr  <= a;
        avs_wdata <= v;
        avs_write <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_req !== 1'b0 && n < 64);
        avs_write <= 1'b0;
        if (n >= 64)
            fail_count++;
        @(posedge clk);
    endtask

    // level register against the flags implied by count and offsets
    task automatic lvl_chk(input int cnt, input int n, input int m, input logic mode);
        logic [31:0] q;
        avs_rd(`FFO_REG_LEVEL, q);
        chk_reg(q, {11'h000, mode, cnt != DEPTH, cnt < DEPTH - m, cnt > n, cnt != 0,
                    16'(cnt)});
        // the flag pins themselves, settled since the last transfer
        chk_reg({28'h0, full_n, afull_n, aempty_n, empty_n},
                {28'h0, cnt != DEPTH, cnt < DEPTH - m, cnt > n, cnt != 0});
    endtask

    task automatic do_reset(input logic s);
        srst  <= 1'b1;
        strap <= s;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #50000;
        fail_count++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        srst = 1'b1;
        strap = 1'b1;
        avs_addr = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_wdata = 32'h0;
        avs_be = 4'hf;
        fail_count = 0;
        samples_checked = 0;
        parts = '{9'h003, 9'h000, 9'h004, 9'h000};
        do_reset(1'b1);
        lvl_chk(0, 7, 7, 1'b0);
        avs_rd(`FFO_REG_OFFSETS, d);
        chk_reg(d, {16'h0007, 16'h0007});
        $display("test reset_defaults done");
        // read asserted in the very cycle after the empty flag clears
        far.push(9'h1a5);
        far.pop(w);
        chk_word(w, 9'h1a5);
        lvl_chk(0, 7, 7, 1'b0);
        $display("test first_word done");
        for (int i = 0; i < DEPTH; i++)
        begin
            far.push(word_t'(i * 37 + 5));
            lvl_chk(i + 1, 7, 7, 1'b0);
        end
        far.push(9'h0ff);
        lvl_chk(DEPTH, 7, 7, 1'b0);
        avs_rd(`FFO_REG_STATUS, d);
        chk_reg(d & 32'h10, 32'h10);
        chk_reg({31'h0, irq}, 32'h0);
        avs_wr(`FFO_REG_MASK, 32'h10);
        avs_rd(`FFO_REG_MASK, d);
        chk_reg(d, 32'h10);
        chk_reg({31'h0, irq}, 32'h1);
        $display("test fill done");
        for (int i = 0; i < DEPTH; i++)
        begin
            far.pop(w);
            chk_word(w, word_t'(i * 37 + 5));
            lvl_chk(DEPTH - 1 - i, 7, 7, 1'b0);
        end
        avs_wr(`FFO_REG_STATUS, 32'h10);
        avs_rd(`FFO_REG_STATUS, d);
        chk_reg(d & 32'h10, 32'h0);
        chk_reg({31'h0, irq}, 32'h0);
        avs_wr(4'h6, 32'hffffffff);
        avs_rd(4'h6, d);
        chk_reg(d, 32'h0);
        avs_rd(`FFO_REG_MASK, d);
        chk_reg(d, 32'h10);
        // no byte lane enabled, so the mask must keep its value
        avs_be <= 4'h0;
        avs_wr(`FFO_REG_MASK, 32'h0);
        avs_be <= 4'hf;
        avs_rd(`FFO_REG_MASK, d);
        chk_reg(d, 32'h10);
        $display("test drain_irq done");
        // load mode: program n=3 m=4, read parts back in the same order
        do_reset(1'b0);
        lvl_chk(0, 7, 7, 1'b1);
        far.load_parts(parts);
        avs_rd(`FFO_REG_OFFSETS, d);
        chk_reg(d, {16'h0004, 16'h0003});
        far.load_readback(back);
        for (int i = 0; i < 4; i++)
            chk_word(back[i], parts[i]);
        for (int i = 0; i < 12; i++)
        begin
            far.push(word_t'(i + 9'h040));
            lvl_chk(i + 1, 3, 4, 1'b1);
        end
        $display("test load_offsets done");
        print_verdict();
    end
endmodule
